/* design/sram_sleep_pkg.sv */
package sram_sleep_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int CLK_PERIOD_NS = 8;
  // ****************************************************************
  // sleep timing, in clock periods
  // ****************************************************************
  localparam int SLEEP_ENTRY_PERIODS = 2;
  localparam int SLEEP_REC_PERIODS = 2;
  localparam int SLEEP_ENTRY_NS = SLEEP_ENTRY_PERIODS * CLK_PERIOD_NS;
  localparam int SLEEP_REC_NS = SLEEP_REC_PERIODS * CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_NS / CLK_PERIOD_NS) < 1 ? 1 : SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int SLEEP_REC_CYC =
    ((SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
    (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_ENTER,
    PWR_SLEEP,
    PWR_RECOVER
  } pwr_state_t;

  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_advance_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic global_write_n;
    logic write_enable_sync_n;
    logic [LANES-1:0] byte_write_lane_n;
  } ctrl_t;
endpackage

/* design/sram_sleep_core.sv */
`timescale 1ns/1ns
module sram_sleep_core
  import sram_sleep_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_select_in,
  input wire logic non_burst_mode_in,
  input wire sram_sleep_pkg::ctrl_t ctrl_in,
  input wire logic [sram_sleep_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sram_sleep_pkg::DATA_W-1:0] data_in,
  output logic [sram_sleep_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic data_valid_out,
  output logic asleep_out,
  output logic unsafe_write_out
);
  import sram_sleep_pkg::*;

  // ****************************************************************
  // sleep request synchroniser and power state
  // ****************************************************************
  logic zz_meta_ff, zz_sync_ff;
  pwr_state_t pwr_ff, nxt_pwr;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;

  always_ff @(posedge clock_in) begin
    zz_meta_ff <= reset_in ? 1'b0 : sleep_request_in;
    zz_sync_ff <= reset_in ? 1'b0 : zz_meta_ff;
  end

  always_comb begin
    nxt_pwr = pwr_ff;
    nxt_cnt = cnt_ff;
    case (pwr_ff)
      PWR_RUN: begin
        if (zz_sync_ff) begin
          nxt_pwr = PWR_ENTER;
          nxt_cnt = CNT_W'(SLEEP_ENTRY_CYC - 1);
        end
      end
      PWR_ENTER: begin
        if (!zz_sync_ff) begin
          nxt_pwr = PWR_RECOVER;
          nxt_cnt = CNT_W'(SLEEP_REC_CYC - 1);
        end else if (cnt_ff == CNT_ZERO) begin
          nxt_pwr = PWR_SLEEP;
        end else begin
          nxt_cnt = cnt_ff - CNT_ONE;
        end
      end
      PWR_SLEEP: begin
        if (!zz_sync_ff) begin
          nxt_pwr = PWR_RECOVER;
          nxt_cnt = CNT_W'(SLEEP_REC_CYC - 1);
        end
      end
      PWR_RECOVER: begin
        if (zz_sync_ff) begin
          nxt_pwr = PWR_ENTER;
          nxt_cnt = CNT_W'(SLEEP_ENTRY_CYC - 1);
        end else if (cnt_ff == CNT_ZERO) begin
          nxt_pwr = PWR_RUN;
        end else begin
          nxt_cnt = cnt_ff - CNT_ONE;
        end
      end
      default: begin
        nxt_pwr = PWR_RUN;
        nxt_cnt = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwr_ff <= PWR_RUN;
      cnt_ff <= CNT_ZERO;
    end else begin
      pwr_ff <= nxt_pwr;
      cnt_ff <= nxt_cnt;
    end
  end

  // ****************************************************************
  // access decode
  // ****************************************************************
  logic asleep, guard_win, clk_en;
  logic sel_ff, nxt_sel;
  logic ads_p, ads_c, sel, wr_req, start;
  logic [LANES-1:0] lane_we;

  function automatic logic chip_selected(input ctrl_t c);
    chip_selected = !c.chip_select_first_n && c.chip_select_second &&
                    !c.chip_select_third_n;
  endfunction

  assign asleep = (pwr_ff == PWR_SLEEP);
  assign guard_win = (pwr_ff == PWR_ENTER) || (pwr_ff == PWR_RECOVER);
  assign clk_en = !asleep;
  assign ads_p = !ctrl_in.processor_address_strobe_n;
  assign ads_c = !ctrl_in.controller_address_strobe_n;
  assign start = (ads_p || ads_c) && chip_selected(ctrl_in);
  assign sel = start || (sel_ff && !(ads_p || ads_c));
  assign lane_we = ctrl_in.global_write_n ?
    (ctrl_in.write_enable_sync_n ? '0 : ~ctrl_in.byte_write_lane_n) : '1;
  assign wr_req = sel && !ads_p && (lane_we != '0);

  // ****************************************************************
  // array, burst counter and pipelined output
  // ****************************************************************
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] rd_addr_ff, nxt_rd_addr;
  logic [ADDR_W-1:0] base_ff, nxt_base;
  logic [1:0] burst_ff, nxt_burst;
  logic rd_pend_ff, nxt_rd_pend;
  logic [DATA_W-1:0] q_ff, nxt_q;
  logic oe_ff, nxt_oe;
  logic bad_ff, nxt_bad;
  logic [ADDR_W-1:0] acc_addr;
  logic [1:0] low_bits;

  // burst_order_select: 1 linear, 0 interleaved
  assign low_bits = burst_order_select_in ?
    base_ff[1:0] + burst_ff : base_ff[1:0] ^ burst_ff;
  assign acc_addr = (ads_p || ads_c) ? addr_in :
    {base_ff[ADDR_W-1:2], low_bits};

  always_comb begin
    nxt_sel = sel_ff;
    nxt_base = base_ff;
    nxt_burst = burst_ff;
    nxt_rd_pend = 1'b0;
    nxt_rd_addr = rd_addr_ff;
    nxt_q = q_ff;
    nxt_oe = oe_ff;
    nxt_bad = 1'b0;
    if (clk_en) begin
      // guard window accesses never select the ram
      nxt_sel = sel && !guard_win;
      if (ads_p || ads_c) begin
        nxt_base = addr_in;
        nxt_burst = BURST_ZERO;
      end else if (!ctrl_in.burst_advance_n && !non_burst_mode_in) begin
        nxt_burst = burst_ff + BURST_ONE;
      end
      nxt_rd_pend = sel && !wr_req && !guard_win;
      nxt_rd_addr = acc_addr;
      // pipelined read: array word latched one cycle after the address
      nxt_q = rd_pend_ff ? mem[rd_addr_ff] : q_ff;
      nxt_oe = rd_pend_ff;
      nxt_bad = guard_win && wr_req;
    end
    if (pwr_ff == PWR_ENTER && nxt_pwr == PWR_SLEEP) begin
      nxt_sel = 1'b0;
      nxt_oe = 1'b0;
      nxt_rd_pend = 1'b0;
    end
    if (pwr_ff == PWR_SLEEP) begin
      nxt_sel = 1'b0;
      nxt_oe = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sel_ff <= 1'b0;
      base_ff <= '0;
      burst_ff <= BURST_ZERO;
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= '0;
      q_ff <= DATA_ZERO;
      oe_ff <= 1'b0;
      bad_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
      base_ff <= nxt_base;
      burst_ff <= nxt_burst;
      rd_pend_ff <= nxt_rd_pend;
      rd_addr_ff <= nxt_rd_addr;
      q_ff <= nxt_q;
      oe_ff <= nxt_oe;
      bad_ff <= nxt_bad;
    end
  end

  // array write, dropped in guard window
  always_ff @(posedge clock_in) begin
    if (clk_en && wr_req && !guard_win) begin
      for (int g = 0; g < LANES; g++) begin
        if (lane_we[g]) begin
          mem[acc_addr][g*LANE_W +: LANE_W] <= data_in[g*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign data_valid_out = oe_ff && (pwr_ff == PWR_RUN) && !zz_sync_ff;
  assign data_out = q_ff;
  assign data_oe_out = oe_ff;
  assign asleep_out = asleep;
  assign unsafe_write_out = bad_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sleep_entry_a: assert property (
    $rose(zz_sync_ff) && pwr_ff == PWR_RUN |-> ##3 pwr_ff == PWR_SLEEP
      or ##1 !zz_sync_ff or ##2 !zz_sync_ff)
    else $error("sleep not reached after the entry window");
  unsafe_flag_a: assert property (
    guard_win && wr_req |=> unsafe_write_out)
    else $error("write in guard window not flagged");
  data_invalid_a: assert property (
    pwr_ff != PWR_RUN |-> !data_valid_out)
    else $error("data marked valid around sleep");
  auto_desel_a: assert property (
    pwr_ff == PWR_SLEEP |=> !sel_ff && !oe_ff)
    else $error("ram selected while asleep");
  clock_gate_a: assert property (
    asleep && $past(asleep) |-> $stable(base_ff) && $stable(burst_ff))
    else $error("state advanced while asleep");
  no_access_a: assert property (
    asleep |=> !rd_pend_ff)
    else $error("read started while asleep");
  recovery_a: assert property (
    pwr_ff == PWR_SLEEP && !zz_sync_ff |=> pwr_ff == PWR_RECOVER ##1
      pwr_ff != PWR_RUN || zz_sync_ff)
    else $error("recovery window too short");
  nonburst_a: assert property (
    non_burst_mode_in && !(ads_p || ads_c) |=> $stable(burst_ff))
    else $error("burst counter moved in non-burst mode");
  write_dec_a: assert property (
    !ctrl_in.global_write_n && sel && !ads_p |-> wr_req)
    else $error("global write not decoded");
  wake_desel_a: assert property (
    $fell(asleep) |-> !sel_ff && !data_oe_out)
    else $error("ram not deselected on wake");

  sleep_c: cover property (pwr_ff == PWR_SLEEP ##1 pwr_ff == PWR_RECOVER);
  read_c: cover property (data_valid_out);
  bad_c: cover property (unsafe_write_out);
endmodule

/* tb/ctrl_model.sv */
`timescale 1ns/1ns
// ********
// cache controller model
// ********
module ctrl_model
  import sram_sleep_pkg::*;
(
  input wire logic clock_in,
  input wire logic sleep_request_in,
  input wire logic op_in,
  input wire logic wr_in,
  input wire logic rude_in,
  input wire logic [1:0] bad_sel_in,
  input wire logic [sram_sleep_pkg::LANES-1:0] lanes_n_in,
  input wire logic [sram_sleep_pkg::DATA_W-1:0] wdata_in,
  output sram_sleep_pkg::ctrl_t ctrl_out,
  output logic [sram_sleep_pkg::DATA_W-1:0] bus_out
);
  logic [2:0] quiet_ff = 3'h0;
  logic [DATA_W-1:0] last_ff = DATA_ZERO;
  logic go;
  always @(posedge clock_in) begin
    if (sleep_request_in)
      quiet_ff <= 3'h6;
    else if (quiet_ff != 3'h0)
      quiet_ff <= quiet_ff - 3'h1;
    last_ff <= bus_out;
  end
  assign go = op_in && (rude_in || (!sleep_request_in && quiet_ff == 3'h0));
  always_comb begin
    ctrl_out.processor_address_strobe_n = 1'b1;
    ctrl_out.controller_address_strobe_n = !go;
    ctrl_out.burst_advance_n = 1'b1;
    ctrl_out.chip_select_first_n = bad_sel_in == 2'h1;
    ctrl_out.chip_select_second = bad_sel_in != 2'h2;
    ctrl_out.chip_select_third_n = bad_sel_in == 2'h3;
    ctrl_out.global_write_n = !(go && wr_in && lanes_n_in == 4'h0);
    ctrl_out.write_enable_sync_n = !(go && wr_in && lanes_n_in != 4'h0);
    ctrl_out.byte_write_lane_n = lanes_n_in;
  end
  // released bus shows the inverse of the last value
  assign bus_out = (go && wr_in) ? wdata_in : ~last_ff;
endmodule

/* tb/sync_sram_sleep_and_nonburst_test.sv */
`timescale 1ns/1ns
// ********
// bench
// ********
module sync_sram_sleep_and_nonburst_test;
  import sram_sleep_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic sleep_request_in = 1'b0;
  logic op = 1'b0;
  logic wr = 1'b0;
  logic rude = 1'b0;
  logic found;
  logic [1:0] bad_sel = 2'h0;
  logic [LANES-1:0] lanes_n = 4'h0;
  logic [ADDR_W-1:0] addr = 16'h0000;
  logic [DATA_W-1:0] wdata = 32'h0000_0000;
  logic [DATA_W-1:0] bus, data_out;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [31:0] seed = 32'h0000_1827;
  ctrl_t ctrl;
  logic data_oe_out, data_valid_out, asleep_out, unsafe_write_out;
  int bad_count = 0;
  int n_tests = 0;
  always #4 clock_in = ~clock_in;
  ctrl_model ctrl_model_inst (.clock_in(clock_in),
    .sleep_request_in(sleep_request_in), .op_in(op), .wr_in(wr),
    .rude_in(rude), .bad_sel_in(bad_sel), .lanes_n_in(lanes_n),
    .wdata_in(wdata), .ctrl_out(ctrl), .bus_out(bus));
  sram_sleep_core sram_sleep_core_inst (.clock_in(clock_in),
    .reset_in(reset_in), .sleep_request_in(sleep_request_in),
    .burst_order_select_in(1'b1), .non_burst_mode_in(1'b1),
    .ctrl_in(ctrl), .addr_in(addr), .data_in(bus), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_valid_out(data_valid_out),
    .asleep_out(asleep_out), .unsafe_write_out(unsafe_write_out));
  task automatic check(input logic [DATA_W-1:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clock_in);
    #1;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o,
    n, input logic [LANES-1:0] ln);
    for (int g = 0; g < LANES; g++)
      if (!ln[g])
        o[g*LANE_W +: LANE_W] = n[g*LANE_W +: LANE_W];
    return o;
  endfunction
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, input logic [LANES-1:0] l,
    input logic [1:0] s, input logic h);
    op = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    lanes_n = l;
    bad_sel = s;
    if (w && s == 2'h0 && !rude)
      mem[a] = merge(mem[a], d, l);
    step();
    if (!h) begin
      op = 1'b0;
      step();
    end
  endtask
  task automatic rd2(input logic [ADDR_W-1:0] a, b);
    acc(1'b0, a, 32'h0000_0000, 4'hf, 2'h0, 1'b1);
    acc(1'b0, b, 32'h0000_0000, 4'hf, 2'h0, 1'b1);
    check(data_out, mem[a]);
    op = 1'b0;
    step();
    check(data_out, mem[b]);
    check({data_oe_out, data_valid_out}, 2'h3);
  endtask
  initial begin
    repeat (6) step();
    reset_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      acc(1'b1, 16'(i), seed, 4'h0, 2'h0, 1'b0);
    end
    acc(1'b1, 16'hffff, 32'h0123_4567, 4'h0, 2'h0, 1'b0);
    rd2(16'hffff, 16'h0000);
    for (int i = 0; i < 60; i++) begin
      seed = lfsr(seed);
      if (seed[4])
        acc(1'b1, {12'h000, seed[3:0]}, lfsr(seed), seed[8:5],
          seed[10:9], 1'b0);
      else
        rd2({12'h000, seed[3:0]}, {12'h000, seed[3:0] ^ 4'h5});
    end
    sleep_request_in = 1'b1;
    repeat (5) step();
    check({asleep_out, data_oe_out, data_valid_out}, 3'h4);
    rude = 1'b1;
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, 16'h0005, ~mem[16'h0005], 4'h0, 2'h0, 1'b0);
      check({asleep_out, data_oe_out, unsafe_write_out}, 3'h4);
    end
    sleep_request_in = 1'b0;
    for (int i = 0; i < 8 && asleep_out; i++)
      step();
    if (asleep_out !== 1'b0) begin
      bad_count++;
      stop_test();
    end
    acc(1'b1, 16'h0005, ~mem[16'h0005], 4'h0, 2'h0, 1'b1);
    op = 1'b0;
    found = 1'b0;
    for (int i = 0; i < 3; i++) begin
      found |= unsafe_write_out === 1'b1;
      step();
    end
    check(found, 1'b1);
    rude = 1'b0;
    repeat (4) step();
    check(data_oe_out, 1'b0);
    rd2(16'h0005, 16'h0006);
    stop_test();
  end
endmodule
